/* File: cbp_parser.sv */
// Top: serial command parser for calibration constants and line rate
`timescale 1ns/10ps
`include "cbp_cfg.svh"

module cbp_parser (
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          serial_rx,
	input  wire logic          baud_lock_jumper,
	output logic               serial_tx,
	output cbp_pkg::cbp_word_t light_cal_temperature,
	output cbp_pkg::cbp_word_t dark_cal_period,
	output cbp_pkg::cbp_word_t dark_cal_temperature,
	output cbp_pkg::cbp_div_t  baud_divisor,
	output logic               baud_locked
);
	import cbp_pkg::*;

	cbp_uart_if  u ();
	cbp_store_if s ();

	cbp_state_t  state;
	cbp_cmd_t    cmd;
	logic [1:0]  pidx;
	logic [3:0]  arg_len;
	logic [3:0]  dig_cnt;
	logic [33:0] acc;
	logic        neg;
	logic        frac_seen;
	logic        tenth_done;
	logic [3:0]  tenths;
	logic        bad;
	cbp_word_t   wval;
	cbp_word_t   echo_val;
	logic [4:0]  ridx;
	logic        jumper_meta;
	logic        jumper_sync;
	logic [7:0]  c;
	logic        is_dig;
	logic        baud_take;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic digit_char(input logic [7:0] ch);
		return (ch >= `CBP_CH_0) && (ch <= `CBP_CH_9);
	endfunction : digit_char

	// Saturating decimal accumulate; saturation keeps huge inputs from wrapping small
	function automatic logic [33:0] acc_dec(input logic [33:0] v, input logic [7:0] ch);
		logic [7:0] d;
		d = ch - `CBP_CH_0;
		if (v > `CBP_ACC_SAT_LIM)
			return `CBP_ACC_SAT;
		return v * 34'd10 + {26'h0, d};
	endfunction : acc_dec

	function automatic logic [7:0] prefix_char(input logic baud, input logic [1:0] i);
		logic [7:0] ch;
		ch = `CBP_CH_SPACE;
		case (i)
			2'h0:    ch = baud ? `CBP_CH_LA : `CBP_CH_LC;
			2'h1:    ch = baud ? `CBP_CH_LU : `CBP_CH_LA;
			2'h2:    ch = baud ? `CBP_CH_LD : `CBP_CH_LL;
			default: ch = `CBP_CH_SPACE;
		endcase
		return ch;
	endfunction : prefix_char

	function automatic logic [7:0] dec_digit(input logic [15:0] v, input int pos);
		logic [15:0] t;
		logic [15:0] r;
		t = v;
		for (int i = 0; i < 7; i++)
			if (i < pos)
				t = t / 16'd10;
		r = t % 16'd10;
		return `CBP_CH_0 + r[7:0];
	endfunction : dec_digit

	// Raw temperature in tenths; hundredths are dropped on entry
	function automatic cbp_word_t temp_word(input logic n, input logic [33:0] m,
		input logic [3:0] f);
		cbp_word_t t;
		t = (m > `CBP_TEMP_MAG_MAX) ? `CBP_TEMP_RAW_MAX : (m[15:0] * 16'd10 + {12'h0, f});
		return n ? (16'h0 - t) : t;
	endfunction : temp_word

	function automatic logic [7:0] reply_char(input cbp_cmd_t k, input logic [4:0] i,
		input cbp_word_t v, input logic lock);
		cbp_word_t  m;
		logic [7:0] ch;
		m  = v[15] ? (16'h0 - v) : v;
		ch = `CBP_CH_SPACE;
		if (k == CMD_QUERY)
		begin
			case (i)
				5'h00:   ch = lock ? `CBP_CH_1 : `CBP_CH_0;
				5'h01:   ch = `CBP_CH_CR;
				default: ch = `CBP_CH_LF;
			endcase
		end
		else if (i == 5'h00)
			ch = `CBP_CH_LZ;
		else if (i == 5'h01 || i == 5'h03)
			ch = `CBP_CH_COMMA;
		else if (i == 5'h02)
			ch = (k == CMD_LIGHT_T) ? `CBP_CH_6 : (k == CMD_DARK_P) ? `CBP_CH_7 : `CBP_CH_8;
		else if (k == CMD_DARK_P)
		begin
			if (i <= 5'h0a)
				ch = dec_digit(v, 10 - int'(i));
			else if (i == 5'h0b)
				ch = `CBP_CH_DOT;
			else if (i <= 5'h0e)
				ch = `CBP_CH_0;
			else if (i == 5'h0f)
				ch = `CBP_CH_LS;
			else if (i == 5'h10)
				ch = `CBP_CH_CR;
			else
				ch = `CBP_CH_LF;
		end
		else
		begin
			// (a negative value shows its sign in the hundreds column)
			case (i)
				5'h04:   ch = v[15] ? `CBP_CH_MINUS : dec_digit(m, 3);
				5'h05:   ch = dec_digit(m, 2);
				5'h06:   ch = dec_digit(m, 1);
				5'h07:   ch = `CBP_CH_DOT;
				5'h08:   ch = dec_digit(m, 0);
				5'h09:   ch = `CBP_CH_UC;
				5'h0a:   ch = `CBP_CH_CR;
				default: ch = `CBP_CH_LF;
			endcase
		end
		return ch;
	endfunction : reply_char

	// ----------------------------------------------------------------
	// Line unit and calibration store
	// ----------------------------------------------------------------
	cbp_uart line_unit (
		.clock     (clock),
		.reset     (reset),
		.serial_rx (serial_rx),
		.serial_tx (serial_tx),
		.u         (u)
	);

	cbp_store cal_store (
		.clock (clock),
		.reset (reset),
		.s     (s)
	);

	assign c         = u.rx_data;
	assign is_dig    = digit_char(c);
	assign u.divisor = baud_divisor;
	assign u.tx_valid = (state == ST_REPLY);
	assign u.tx_data = reply_char(cmd, ridx, echo_val, baud_locked);
	assign s.we      = (state == ST_WRITE);
	assign s.re      = (state == ST_READ);
	assign s.wdata   = wval;
	assign s.addr    = (cmd == CMD_LIGHT_T) ? `CBP_SLOT_LIGHT_T :
	                   (cmd == CMD_DARK_P)  ? `CBP_SLOT_DARK_P  :
	                   (cmd == CMD_DARK_T)  ? `CBP_SLOT_DARK_T  : 2'h3;
	assign baud_take = (state == ST_ARG) && u.rx_valid && (cmd == CMD_BAUD) &&
	                   (c == `CBP_CH_LX) && !bad && (dig_cnt == `CBP_BAUD_DIGITS);

	// ----------------------------------------------------------------
	// Lock jumper and line rate
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			jumper_meta <= 1'b0;
			jumper_sync <= 1'b0;
			baud_locked <= 1'b0;
		end
		else
		begin
			jumper_meta <= baud_lock_jumper;
			jumper_sync <= jumper_meta;
			baud_locked <= jumper_sync;
		end

	// Reset rate is the locked rate, so a fitted jumper always restarts at it
	always_ff @(posedge clock or posedge reset)
		if (reset)
			baud_divisor <= `CBP_DIV_RESET;
		else if (baud_take && !baud_locked)
			baud_divisor <= (acc > `CBP_DIV_MAX) ? 32'hffff_ffff : acc[31:0];

	// ----------------------------------------------------------------
	// Retained copies for the measurement logic
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			light_cal_temperature <= `CBP_STORE_RESET;
			dark_cal_period       <= `CBP_STORE_RESET;
			dark_cal_temperature  <= `CBP_STORE_RESET;
		end
		else if (state == ST_LATCH)
		begin
			if (cmd == CMD_LIGHT_T)
				light_cal_temperature <= s.rdata;
			if (cmd == CMD_DARK_P)
				dark_cal_period <= s.rdata;
			if (cmd == CMD_DARK_T)
				dark_cal_temperature <= s.rdata;
		end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	// Characters arriving while a reply is sent are dropped
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			state      <= ST_IDLE;
			cmd        <= CMD_QUERY;
			pidx       <= 2'h0;
			arg_len    <= 4'h0;
			dig_cnt    <= 4'h0;
			acc        <= 34'h0;
			neg        <= 1'b0;
			frac_seen  <= 1'b0;
			tenth_done <= 1'b0;
			tenths     <= 4'h0;
			bad        <= 1'b0;
			wval       <= `CBP_STORE_RESET;
			echo_val   <= `CBP_STORE_RESET;
			ridx       <= 5'h00;
		end
		else
		begin
			case (state)
				ST_IDLE:
					if (u.rx_valid)
					begin
						pidx       <= 2'h0;
						arg_len    <= 4'h0;
						dig_cnt    <= 4'h0;
						acc        <= 34'h0;
						neg        <= 1'b0;
						frac_seen  <= 1'b0;
						tenth_done <= 1'b0;
						tenths     <= 4'h0;
						bad        <= 1'b0;
						if (c == `CBP_CH_LZ)
						begin
							cmd   <= CMD_LIGHT_T;
							state <= ST_PREFIX;
						end
						else if (c == `CBP_CH_LB)
						begin
							cmd   <= CMD_BAUD;
							state <= ST_PREFIX;
						end
						else if (c == `CBP_CH_UB)
						begin
							cmd   <= CMD_QUERY;
							state <= ST_QUERY;
						end
					end
				ST_PREFIX:
					if (u.rx_valid)
					begin
						if (c != prefix_char(cmd == CMD_BAUD, pidx))
							state <= ST_IDLE;
						else if (pidx == 2'h2)
							state <= (cmd == CMD_BAUD) ? ST_ARG : ST_SELECT;
						else
							pidx <= pidx + 2'h1;
					end
				ST_SELECT:
					if (u.rx_valid)
					begin
						state <= ST_ARG;
						if (c == `CBP_CH_6)
							cmd <= CMD_LIGHT_T;
						else if (c == `CBP_CH_7)
							cmd <= CMD_DARK_P;
						else if (c == `CBP_CH_8)
							cmd <= CMD_DARK_T;
						else
							state <= ST_IDLE;
					end
				ST_QUERY:
					if (u.rx_valid)
					begin
						ridx  <= 5'h00;
						state <= (c == `CBP_CH_LX) ? ST_REPLY : ST_IDLE;
					end
				ST_ARG:
					if (u.rx_valid)
					begin
						arg_len <= arg_len + 4'h1;
						if (arg_len == `CBP_MAX_ARG)
							state <= ST_IDLE;
						else if (c == `CBP_CH_LX)
						begin
							state <= ST_IDLE;
							if (cmd == CMD_DARK_P && !bad && dig_cnt != 4'h0)
							begin
								wval  <= (acc > `CBP_DARK_MAX_S) ? 16'(`CBP_DARK_MAX_S) : acc[15:0];
								state <= ST_WRITE;
							end
							else if ((cmd == CMD_LIGHT_T || cmd == CMD_DARK_T) && !bad)
							begin
								wval  <= temp_word(neg, acc, tenths);
								state <= ST_WRITE;
							end
						end
						else if (is_dig)
						begin
							dig_cnt <= dig_cnt + 4'h1;
							if (frac_seen)
							begin
								if (!tenth_done)
									tenths <= 4'(c - `CBP_CH_0);
								tenth_done <= 1'b1;
							end
							else
								acc <= acc_dec(acc, c);
							if (cmd == CMD_DARK_P && !bad && dig_cnt + 4'h1 == `CBP_PERIOD_DIGITS)
							begin
								wval  <= (acc_dec(acc, c) > `CBP_DARK_MAX_S) ?
								         16'(`CBP_DARK_MAX_S) : 16'(acc_dec(acc, c));
								state <= ST_WRITE;
							end
						end
						else if ((cmd == CMD_LIGHT_T || cmd == CMD_DARK_T) && c == `CBP_CH_MINUS)
							neg <= 1'b1;
						else if ((cmd == CMD_LIGHT_T || cmd == CMD_DARK_T) &&
						         (c == `CBP_CH_PLUS || c == `CBP_CH_SPACE))
							neg <= neg;
						else if ((cmd == CMD_LIGHT_T || cmd == CMD_DARK_T) &&
						         c == `CBP_CH_DOT && !frac_seen)
							frac_seen <= 1'b1;
						else
							bad <= 1'b1;
					end
				ST_WRITE:
					state <= ST_READ;
				ST_READ:
					state <= ST_LATCH;
				ST_LATCH:
				begin
					echo_val <= s.rdata;
					ridx     <= 5'h00;
					state    <= ST_REPLY;
				end
				ST_REPLY:
					if (u.tx_ready)
					begin
						ridx <= ridx + 5'h01;
						if (ridx + 5'h01 == ((cmd == CMD_QUERY) ? `CBP_LEN_QUERY :
						                     (cmd == CMD_DARK_P) ? `CBP_LEN_PERIOD : `CBP_LEN_TEMP))
							state <= ST_IDLE;
					end
				default:
					state <= ST_IDLE;
			endcase
		end

endmodule : cbp_parser

/* File: cbp_cfg.svh */
// Constants for the calibration and baud command parser
`ifndef CBP_CFG_SVH
`define CBP_CFG_SVH

// ----------------------------------------------------------------
// Clock and line rate
// ----------------------------------------------------------------
`define CBP_CLK_HZ        20000000
`define CBP_OVERSAMPLE    4
`define CBP_LOCK_BAUD     115200
`define CBP_LOCK_DIV      ((`CBP_CLK_HZ / (`CBP_OVERSAMPLE * `CBP_LOCK_BAUD)) - 1)
`define CBP_DIV_RESET     32'(`CBP_LOCK_DIV)
`define CBP_DIV_MAX       34'h0_ffff_ffff

// ----------------------------------------------------------------
// Argument limits
// ----------------------------------------------------------------
`define CBP_BAUD_DIGITS   4'ha
`define CBP_PERIOD_DIGITS 4'h6
`define CBP_MAX_ARG       4'hf
`define CBP_DARK_MAX_S    34'h0_0000_012c
`define CBP_TEMP_MAG_MAX  34'h0_0000_03e7
`define CBP_TEMP_RAW_MAX  16'h270f
`define CBP_ACC_SAT_LIM   34'h0_6666_6665
`define CBP_ACC_SAT       34'h3_ffff_ffff

// ----------------------------------------------------------------
// Storage slots and reset value
// ----------------------------------------------------------------
`define CBP_SLOT_LIGHT_T  2'h0
`define CBP_SLOT_DARK_P   2'h1
`define CBP_SLOT_DARK_T   2'h2
`define CBP_STORE_RESET   16'h0000

// ----------------------------------------------------------------
// Reply lengths
// ----------------------------------------------------------------
`define CBP_LEN_TEMP      5'h0c
`define CBP_LEN_PERIOD    5'h12
`define CBP_LEN_QUERY     5'h03

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define CBP_CH_LZ     8'h7a
`define CBP_CH_LC     8'h63
`define CBP_CH_LA     8'h61
`define CBP_CH_LL     8'h6c
`define CBP_CH_LB     8'h62
`define CBP_CH_LU     8'h75
`define CBP_CH_LD     8'h64
`define CBP_CH_UB     8'h42
`define CBP_CH_LX     8'h78
`define CBP_CH_LS     8'h73
`define CBP_CH_UC     8'h43
`define CBP_CH_COMMA  8'h2c
`define CBP_CH_DOT    8'h2e
`define CBP_CH_MINUS  8'h2d
`define CBP_CH_PLUS   8'h2b
`define CBP_CH_SPACE  8'h20
`define CBP_CH_CR     8'h0d
`define CBP_CH_LF     8'h0a
`define CBP_CH_0      8'h30
`define CBP_CH_1      8'h31
`define CBP_CH_6      8'h36
`define CBP_CH_7      8'h37
`define CBP_CH_8      8'h38
`define CBP_CH_9      8'h39

`endif

/* File: cbp_pkg.sv */
// Types for the calibration and baud command parser
package cbp_pkg;

	typedef logic [15:0] cbp_word_t;
	typedef logic [31:0] cbp_div_t;

	typedef enum logic [2:0] {
		CMD_LIGHT_T = 3'h0,
		CMD_DARK_P  = 3'h1,
		CMD_DARK_T  = 3'h2,
		CMD_BAUD    = 3'h3,
		CMD_QUERY   = 3'h4
	} cbp_cmd_t;

	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_PREFIX = 9'h002,
		ST_SELECT = 9'h004,
		ST_ARG    = 9'h008,
		ST_QUERY  = 9'h010,
		ST_WRITE  = 9'h020,
		ST_READ   = 9'h040,
		ST_LATCH  = 9'h080,
		ST_REPLY  = 9'h100
	} cbp_state_t;

endpackage : cbp_pkg

/* File: cbp_if.sv */
// Internal carriers between parser, line unit and calibration store
`timescale 1ns/10ps

interface cbp_uart_if;
	logic                 rx_valid;
	logic [7:0]           rx_data;
	logic                 tx_valid;
	logic [7:0]           tx_data;
	logic                 tx_ready;
	cbp_pkg::cbp_div_t    divisor;

	modport uart   (input tx_valid, tx_data, divisor, output rx_valid, rx_data, tx_ready);
	modport parser (output tx_valid, tx_data, divisor, input rx_valid, rx_data, tx_ready);
endinterface : cbp_uart_if

interface cbp_store_if;
	logic                 we;
	logic                 re;
	logic [1:0]           addr;
	cbp_pkg::cbp_word_t   wdata;
	cbp_pkg::cbp_word_t   rdata;

	modport store  (input we, re, addr, wdata, output rdata);
	modport parser (output we, re, addr, wdata, input rdata);
endinterface : cbp_store_if

/* File: cbp_uart.sv */
// Serial line unit: 8N1 receiver and transmitter on a quarter-bit tick
`timescale 1ns/10ps
`include "cbp_cfg.svh"

module cbp_uart (
	input  wire logic  clock,
	input  wire logic  reset,
	input  wire logic  serial_rx,
	output logic       serial_tx,
	cbp_uart_if.uart   u
);
	import cbp_pkg::*;

	logic        rx_meta;
	logic        rx_sync;
	cbp_div_t    tick_cnt;
	logic        tick;
	logic        rx_busy;
	logic [1:0]  rx_wait;
	logic [3:0]  rx_bit;
	logic [7:0]  rx_shift;
	logic        tx_busy;
	logic [9:0]  tx_shift;
	logic [1:0]  tx_sub;
	logic [3:0]  tx_bit;

	// ----------------------------------------------------------------
	// Pin synchroniser and quarter-bit divider
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end
		else
		begin
			rx_meta <= serial_rx;
			rx_sync <= rx_meta;
		end

	// A new divisor takes effect at once; >= keeps a shrinking divisor from overrunning
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end
		else if (tick_cnt >= u.divisor)
		begin
			tick_cnt <= 32'h0;
			tick     <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h1;
			tick     <= 1'b0;
		end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			rx_busy    <= 1'b0;
			rx_wait    <= 2'h0;
			rx_bit     <= 4'h0;
			rx_shift   <= 8'h00;
			u.rx_valid <= 1'b0;
			u.rx_data  <= 8'h00;
		end
		else
		begin
			u.rx_valid <= 1'b0;
			if (tick)
			begin
				if (!rx_busy)
				begin
					// Start edge seen: first sample lands near mid start bit
					if (!rx_sync)
					begin
						rx_busy <= 1'b1;
						rx_wait <= 2'h1;
						rx_bit  <= 4'h0;
					end
				end
				else if (rx_wait != 2'h0)
					rx_wait <= rx_wait - 2'h1;
				else
				begin
					rx_wait <= 2'h3;
					rx_bit  <= rx_bit + 4'h1;
					if (rx_bit == 4'h0 && rx_sync)
						rx_busy <= 1'b0;
					else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
						rx_shift <= {rx_sync, rx_shift[7:1]};
					else if (rx_bit == 4'h9)
					begin
						rx_busy    <= 1'b0;
						u.rx_valid <= rx_sync;
						u.rx_data  <= rx_shift;
					end
				end
			end
		end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	assign u.tx_ready = !tx_busy;

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			tx_busy   <= 1'b0;
			tx_shift  <= 10'h3ff;
			tx_sub    <= 2'h0;
			tx_bit    <= 4'h0;
			serial_tx <= 1'b1;
		end
		else
		begin
			serial_tx <= tx_shift[0];
			if (!tx_busy)
			begin
				if (u.tx_valid)
				begin
					tx_busy  <= 1'b1;
					tx_shift <= {1'b1, u.tx_data, 1'b0};
					tx_sub   <= 2'h0;
					tx_bit   <= 4'h0;
				end
			end
			else if (tick)
			begin
				tx_sub <= tx_sub + 2'h1;
				if (tx_sub == 2'h3)
				begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					tx_bit   <= tx_bit + 4'h1;
					if (tx_bit == 4'h9)
						tx_busy <= 1'b0;
				end
			end
		end

endmodule : cbp_uart

/* File: cbp_store.sv */
// Calibration store: three retained words with registered read data
`timescale 1ns/10ps
`include "cbp_cfg.svh"

module cbp_store (
	input  wire logic  clock,
	input  wire logic  reset,
	cbp_store_if.store s
);
	import cbp_pkg::*;

	cbp_word_t mem [0:2];

	// Read-back after write lets the echo show what was really retained
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			for (int i = 0; i < 3; i++)
				mem[i] <= `CBP_STORE_RESET;
			s.rdata <= `CBP_STORE_RESET;
		end
		else
		begin
			if (s.we && s.addr != 2'h3)
				mem[s.addr] <= s.wdata;
			if (s.re)
				s.rdata <= (s.addr == 2'h3) ? `CBP_STORE_RESET : mem[s.addr];
		end

endmodule : cbp_store

/* File: cbp_props.sv */
// Port-level assertions for the calibration and baud command parser
`timescale 1ns/10ps

module cbp_props (
	input wire logic               clock,
	input wire logic               reset,
	input wire logic               baud_lock_jumper,
	input wire logic               serial_tx,
	input wire cbp_pkg::cbp_word_t light_cal_temperature,
	input wire cbp_pkg::cbp_word_t dark_cal_period,
	input wire cbp_pkg::cbp_word_t dark_cal_temperature,
	input wire cbp_pkg::cbp_div_t  baud_divisor,
	input wire logic               baud_locked
);
	import cbp_pkg::*;

	// ----------------------------------------------------------------
	// Stored values and line rate
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	period_cap_a: assert property (dark_cal_period <= 16'h012c)
		else $error("dark period above cap");
	temp_range_a: assert property ($signed(light_cal_temperature) <= 16'sh270f
		&& $signed(light_cal_temperature) >= -16'sh270f) else $error("light temp out of range");
	reset_rate_a: assert property ($fell(reset) |-> baud_divisor == 32'h0000_002a)
		else $error("divisor not at default rate after reset");
	locked_hold_a: assert property (baud_locked && $past(baud_locked) |-> $stable(baud_divisor))
		else $error("divisor moved while locked");
	// A new rate must not be followed by a start bit within 8 cycles
	baud_quiet_a: assert property ($changed(baud_divisor) |-> serial_tx [*8])
		else $error("reply after rate change");

	// ----------------------------------------------------------------
	// Echo follows every stored change; jumper reaches baud_locked
	// ----------------------------------------------------------------
	light_echo_a: assert property ($changed(light_cal_temperature) |-> ##[1:12] !serial_tx)
		else $error("no echo after light temp store");
	dark_p_echo_a: assert property ($changed(dark_cal_period) |-> ##[1:12] !serial_tx)
		else $error("no echo after dark period store");
	dark_t_echo_a: assert property ($changed(dark_cal_temperature) |-> ##[1:12] !serial_tx)
		else $error("no echo after dark temp store");
	lock_rise_a: assert property ($rose(baud_lock_jumper) |-> ##[1:5] baud_locked)
		else $error("jumper not seen as locked");
endmodule : cbp_props

/* File: cbp_host.sv */
// Host computer model on the serial link: sender and free-running receiver
`timescale 1ns/10ps

module cbp_host (
	input  wire logic clock,
	input  wire logic line_in,
	output logic      line_out
);
	int         div = 42;
	logic [7:0] rxq[$];

	initial line_out = 1'b1;

	task automatic bit_wait(input int n);
		repeat (n * (div + 1)) @(posedge clock);
	endtask : bit_wait

	// Whole characters only: start low, LSB first, stop high
	task automatic send_str(input string s);
		logic [9:0] fr;
		for (int i = 0; i < s.len(); i++)
		begin
			fr = {1'b1, s[i], 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				#1 line_out = fr[b];
				bit_wait(4);
			end
		end
	endtask : send_str

	// Runs ahead of the sender, since a reply may start before the stop bit ends
	initial
	begin
		logic [7:0] ch;
		forever
		begin
			@(negedge line_in);
			bit_wait(2);
			for (int b = 0; b < 8; b++)
			begin
				bit_wait(4);
				ch[b] = line_in;
			end
			bit_wait(4);
			rxq.push_back(ch);
		end
	end
endmodule : cbp_host

/* File: tb_top.sv */
// Self-checking bench for the calibration and baud command parser
`timescale 1ns/10ps

module tb_top;
	import cbp_pkg::*;

	logic      clock;
	logic      reset;
	logic      jumper;
	logic      rx_line;
	logic      tx_line;
	logic      locked;
	cbp_word_t light_t;
	cbp_word_t dark_p;
	cbp_word_t dark_t;
	cbp_div_t  div;
	int        err_total = 0;
	int        total_checks = 0;

	cbp_parser dut (.clock(clock), .reset(reset), .serial_rx(rx_line), .baud_lock_jumper(jumper),
		.serial_tx(tx_line), .light_cal_temperature(light_t), .dark_cal_period(dark_p),
		.dark_cal_temperature(dark_t), .baud_divisor(div), .baud_locked(locked));
	cbp_host host (.clock(clock), .line_in(tx_line), .line_out(rx_line));

	// ----------------------------------------------------------------
	// Shared checks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : check

	task automatic expect_reply(input string s);
		for (int n = 0; n < 20000 && host.rxq.size() < s.len(); n++) @(posedge clock);
		repeat (200) @(posedge clock);
		check("reply length", s.len(), host.rxq.size());
		for (int i = 0; i < s.len() && i < host.rxq.size(); i++) check("reply char", s[i], host.rxq[i]);
		host.rxq.delete();
	endtask : expect_reply

	task automatic expect_quiet();
		repeat (400) @(posedge clock);
		check("silent reply", 0, host.rxq.size());
		host.rxq.delete();
	endtask : expect_quiet

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_baud();
		host.send_str("baud0000000003x");
		check("baud_divisor", 32'h0000_0003, div);
		host.div = 3;
		expect_quiet();
	endtask : t_baud

	task automatic t_light();
		host.send_str({"zcal", "6-012.37x"});
		expect_reply("z,6,-12.3C\015\012");
		check("light temp", 16'hff85, light_t);
	endtask : t_light

	task automatic t_period();
		host.send_str({"zcal", "7000400"});
		expect_reply("z,7,0000300.000s\015\012");
		check("dark period", 16'h012c, dark_p);
		host.send_str({"zcal", "745x"});
		expect_reply("z,7,0000045.000s\015\012");
		check("dark period x", 16'h002d, dark_p);
	endtask : t_period

	task automatic t_dark();
		host.send_str({"zcal", "8019.0"});
		repeat (100) @(posedge clock);
		check("dark temp early", 16'h0000, dark_t);
		host.send_str("x");
		expect_reply("z,8,019.0C\015\012");
		check("dark temp", 16'h00be, dark_t);
	endtask : t_dark

	task automatic t_bad();
		host.send_str({"zcal", "81a.0x"});
		expect_quiet();
		check("dark temp kept", 16'h00be, dark_t);
	endtask : t_bad

	task automatic t_lock();
		host.send_str({"B", "x"});
		expect_reply("0\015\012");
		@(posedge clock);
		#1 jumper = 1'b1;
		repeat (6) @(posedge clock);
		check("baud_locked", 1, locked);
		host.send_str({"B", "x"});
		expect_reply("1\015\012");
		host.send_str("baud0000000005x");
		expect_quiet();
		check("locked divisor", 32'h0000_0003, div);
		@(posedge clock);
		#1 reset = 1'b1;
		repeat (8) @(posedge clock);
		#1 reset = 1'b0;
		repeat (6) @(posedge clock);
		check("reset divisor", 32'h0000_002a, div);
		host.div = 42;
		host.send_str({"B", "x"});
		expect_reply("1\015\012");
	endtask : t_lock

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Whole run is about 59000 cycles, mostly the slow-rate commands
	initial
	begin
		repeat (90000) @(posedge clock);
		err_total++;
		complete_run();
	end

	initial
	begin
		reset = 1'b1;
		jumper = 1'b0;
		repeat (8) @(posedge clock);
		#1 reset = 1'b0;
		repeat (4) @(posedge clock);
		t_baud();
		t_light();
		t_period();
		t_dark();
		t_bad();
		t_lock();
		complete_run();
	end
endmodule : tb_top

bind cbp_parser cbp_props chk (.clock(clock), .reset(reset), .baud_lock_jumper(baud_lock_jumper),
	.serial_tx(serial_tx), .light_cal_temperature(light_cal_temperature),
	.dark_cal_period(dark_cal_period), .dark_cal_temperature(dark_cal_temperature),
	.baud_divisor(baud_divisor), .baud_locked(baud_locked));
